// [hdl/hiec_ctrl.sv]
// host interrupt, byte-order and export control of the security processor
`timescale 1ns/100ps
// Contract
// - record done raises irq when enabled, unsuppressed
// - each queue governed by its own enable
// - suppress flag blocks record completion irq
// - done status sticky, write one clears
// - queue fifo emptying raises irq if enabled
// - drained status cleared by own or done
// - dma error raises irq if enabled, own status bit
// - export high allows only single des or no cipher
// - export low enables all ciphers
// - export pin pulled up, restricted default
// - le flag zero swaps dma structures
// - normal flag zero swaps all bus words
// - both byte-order flags reset to one
// - payload bytes never swapped by le flag
module hiec_ctrl (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic sym_queue_irq_enable_i,
  input wire logic asym_queue_irq_enable_i,
  input wire logic dma_fault_irq_enable_i,
  input wire logic sym_record_done_i,
  input wire logic sym_record_suppress_i,
  input wire logic asym_record_done_i,
  input wire logic asym_record_suppress_i,
  input wire logic sym_queue_empty_i,
  input wire logic asym_queue_empty_i,
  input wire logic dma_fault_i,
  input wire logic [hiec_pkg::HIEC_ST_W-1:0] status_clear_i,
  input wire logic status_clear_we_i,
  input wire logic flags_we_i,
  input wire logic little_endian_host_flag_i,
  input wire logic normal_bus_flag_i,
  input wire logic export_pin_i,
  input wire logic export_pin_oe_i,
  input wire hiec_pkg::hiec_cipher_t cipher_req_i,
  input wire logic cipher_req_valid_i,
  input wire hiec_pkg::hiec_dma_kind_t dma_kind_i,
  input wire logic [31:0] dma_data_i,
  input wire logic [31:0] bus_data_i,
  output logic [31:0] dma_data_o,
  output logic [31:0] bus_data_o,
  output logic cipher_grant_o,
  output logic cipher_refuse_o,
  output logic export_mode_o,
  output logic little_endian_host_flag_o,
  output logic normal_bus_flag_o,
  output logic sym_queue_done_status_o,
  output logic asym_queue_done_status_o,
  output logic sym_queue_drained_status_o,
  output logic asym_queue_drained_status_o,
  output logic dma_fault_status_o,
  output logic irq_o
);
  // ***********************************
  // reset release and pin synchroniser
  // ***********************************
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire logic rst_n = rst_sync_reg;

  // an undriven pin reads high through the pull-up, so export is the default
  logic export_level;
  assign export_level = export_pin_oe_i ? export_pin_i : 1'b1;
  logic exp_meta_reg;
  logic exp_sync_reg;
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exp_meta_reg <= 1'b1;
      exp_sync_reg <= 1'b1;
    end
    else
    begin
      exp_meta_reg <= export_level;
      exp_sync_reg <= exp_meta_reg;
    end
  end

  // ***********************************
  // interrupt status
  // ***********************************
  logic [hiec_pkg::HIEC_ST_W-1:0] status_reg;
  logic [hiec_pkg::HIEC_ST_W-1:0] status_next;
  logic sym_empty_reg;
  logic asym_empty_reg;
  logic [hiec_pkg::HIEC_ST_W-1:0] set_v;
  logic [hiec_pkg::HIEC_ST_W-1:0] clr_v;
  always_comb
  begin
    set_v = '0;
    clr_v = '0;
    set_v[hiec_pkg::HIEC_ST_SYM_DONE] = sym_record_done_i && !sym_record_suppress_i
      && sym_queue_irq_enable_i;
    set_v[hiec_pkg::HIEC_ST_ASYM_DONE] = asym_record_done_i && !asym_record_suppress_i
      && asym_queue_irq_enable_i;
    set_v[hiec_pkg::HIEC_ST_SYM_DRAIN] = sym_queue_empty_i && !sym_empty_reg && sym_queue_irq_enable_i;
    set_v[hiec_pkg::HIEC_ST_ASYM_DRAIN] = asym_queue_empty_i && !asym_empty_reg
      && asym_queue_irq_enable_i;
    set_v[hiec_pkg::HIEC_ST_DMA_FAULT] = dma_fault_i && dma_fault_irq_enable_i;
    if (status_clear_we_i)
    begin
      clr_v = status_clear_i;
      clr_v[hiec_pkg::HIEC_ST_SYM_DRAIN] = status_clear_i[hiec_pkg::HIEC_ST_SYM_DRAIN]
        | status_clear_i[hiec_pkg::HIEC_ST_SYM_DONE];
      clr_v[hiec_pkg::HIEC_ST_ASYM_DRAIN] = status_clear_i[hiec_pkg::HIEC_ST_ASYM_DRAIN]
        | status_clear_i[hiec_pkg::HIEC_ST_ASYM_DONE];
    end
    // a new event in the clearing cycle wins
    status_next = (status_reg & ~clr_v) | set_v;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_reg <= '0;
      sym_empty_reg <= 1'b1;
      asym_empty_reg <= 1'b1;
    end
    else
    begin
      status_reg <= status_next;
      sym_empty_reg <= sym_queue_empty_i;
      asym_empty_reg <= asym_queue_empty_i;
    end
  end
  assign sym_queue_done_status_o = status_reg[hiec_pkg::HIEC_ST_SYM_DONE];
  assign asym_queue_done_status_o = status_reg[hiec_pkg::HIEC_ST_ASYM_DONE];
  assign sym_queue_drained_status_o = status_reg[hiec_pkg::HIEC_ST_SYM_DRAIN];
  assign asym_queue_drained_status_o = status_reg[hiec_pkg::HIEC_ST_ASYM_DRAIN];
  assign dma_fault_status_o = status_reg[hiec_pkg::HIEC_ST_DMA_FAULT];
  assign irq_o = |status_reg;

  // ***********************************
  // byte-order flags
  // ***********************************
  logic le_reg;
  logic le_next;
  logic nb_reg;
  logic nb_next;
  always_comb
  begin
    le_next = le_reg;
    nb_next = nb_reg;
    if (flags_we_i)
    begin
      le_next = little_endian_host_flag_i;
      nb_next = normal_bus_flag_i;
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      le_reg <= hiec_pkg::HIEC_LE_HOST_RST;
      nb_reg <= hiec_pkg::HIEC_NORMAL_BUS_RST;
    end
    else
    begin
      le_reg <= le_next;
      nb_reg <= nb_next;
    end
  end
  assign little_endian_host_flag_o = le_reg;
  assign normal_bus_flag_o = nb_reg;

  // ***********************************
  // data swapping
  // ***********************************
  logic struct_swap;
  assign struct_swap = !le_reg && (dma_kind_i != hiec_pkg::HIEC_DS_PAYLOAD);
  logic [31:0] dma_sw;
  logic [31:0] bus_sw;
  // structure swap on the dma path, whole-bus swap on the separate bus path
  hiec_swap #(.WIDTH(32)) u_struct_swap (
    .en_i(struct_swap),
    .data_i(dma_data_i),
    .data_o(dma_sw)
  );
  hiec_swap #(.WIDTH(32)) u_bus_swap (
    .en_i(!nb_reg),
    .data_i(bus_data_i),
    .data_o(bus_sw)
  );
  logic [31:0] dma_data_reg;
  logic [31:0] bus_data_reg;
  logic grant_reg;
  logic refuse_reg;
  logic grant_next;
  logic refuse_next;
  always_comb
  begin
    grant_next = 1'b0;
    refuse_next = 1'b0;
    if (cipher_req_valid_i)
    begin
      if (!exp_sync_reg)
      begin
        grant_next = 1'b1;
      end
      else
      begin
        case (cipher_req_i)
          hiec_pkg::HIEC_CIPH_DES56, hiec_pkg::HIEC_CIPH_NONE: grant_next = 1'b1;
          default: refuse_next = 1'b1;
        endcase
      end
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dma_data_reg <= 32'h0000_0000;
      bus_data_reg <= 32'h0000_0000;
      grant_reg <= 1'b0;
      refuse_reg <= 1'b0;
    end
    else
    begin
      dma_data_reg <= dma_sw;
      bus_data_reg <= bus_sw;
      grant_reg <= grant_next;
      refuse_reg <= refuse_next;
    end
  end
  assign dma_data_o = dma_data_reg;
  assign bus_data_o = bus_data_reg;
  assign cipher_grant_o = grant_reg;
  assign cipher_refuse_o = refuse_reg;
  assign export_mode_o = exp_sync_reg;
endmodule

// [hdl/hiec_pkg.sv]
// package of constants for the host interrupt, byte-order and export control block
package hiec_pkg;
  // byte-order flag reset values
  localparam logic HIEC_LE_HOST_RST = 1'b1;
  localparam logic HIEC_NORMAL_BUS_RST = 1'b1;
  // positions of the write-one-to-clear status bits
  localparam int HIEC_ST_SYM_DONE = 0;
  localparam int HIEC_ST_ASYM_DONE = 1;
  localparam int HIEC_ST_SYM_DRAIN = 2;
  localparam int HIEC_ST_ASYM_DRAIN = 3;
  localparam int HIEC_ST_DMA_FAULT = 4;
  localparam int HIEC_ST_W = 5;
  // bulk cipher selector codes
  typedef enum logic [2:0]
  {
    HIEC_CIPH_NONE,
    HIEC_CIPH_DES56,
    HIEC_CIPH_3DES,
    HIEC_CIPH_AES,
    HIEC_CIPH_STREAM
  } hiec_cipher_t;
  // structure classes seen by the dma engine
  typedef enum logic [2:0]
  {
    HIEC_DS_PAYLOAD,
    HIEC_DS_RECORD,
    HIEC_DS_CONTEXT,
    HIEC_DS_CHAIN,
    HIEC_DS_BIGNUM,
    HIEC_DS_STREAM_STATE
  } hiec_dma_kind_t;
endpackage

// [hdl/hiec_swap.sv]
// byte lane reversal of one word, enabled per call
`timescale 1ns/100ps
module hiec_swap #(
  parameter int WIDTH = 32
) (
  input wire logic en_i,
  input wire logic [WIDTH-1:0] data_i,
  output logic [WIDTH-1:0] data_o
);
  localparam int NB = WIDTH / 8;
  logic [WIDTH-1:0] rev;
  // refused at elaboration: a partial byte lane has no partner to swap with
  if (WIDTH % 8 != 0 || WIDTH < 8)
  begin : g_bad_width
    $error("hiec_swap: WIDTH must be a multiple of 8");
  end
  genvar b;
  generate
    for (b = 0; b < NB; b = b + 1)
    begin : g_lane
      assign rev[8*b +: 8] = data_i[8*(NB-1-b) +: 8];
    end
  endgenerate
  assign data_o = en_i ? rev : data_i;
endmodule

// [verif/hiec_ctrl_properties.sv]
// assertions on the ports of the host control block
`timescale 1ns/100ps
module hiec_ctrl_properties (
  input wire logic ref_clk_i, nrst_i, sym_queue_irq_enable_i, dma_fault_irq_enable_i, dma_fault_i,
  input wire logic sym_record_done_i, sym_record_suppress_i, sym_queue_empty_i, status_clear_we_i,
  input wire logic [hiec_pkg::HIEC_ST_W-1:0] status_clear_i,
  input wire hiec_pkg::hiec_cipher_t cipher_req_i,
  input wire logic cipher_req_valid_i, cipher_grant_o, cipher_refuse_o, export_mode_o, normal_bus_flag_o,
  input wire logic [31:0] bus_data_i, bus_data_o,
  input wire logic sym_queue_done_status_o, sym_queue_drained_status_o, dma_fault_status_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_fire;
    sym_record_done_i && sym_queue_irq_enable_i && !sym_record_suppress_i;
  endsequence
  sequence s_hush;
    sym_record_done_i && sym_record_suppress_i && !sym_queue_done_status_o;
  endsequence
  // a set in the same cycle beats the clear, so those cycles are left out
  sequence s_clear;
    status_clear_we_i && status_clear_i[0] && !sym_record_done_i && !sym_queue_empty_i;
  endsequence
  sequence s_strong;
    cipher_req_valid_i && export_mode_o && cipher_req_i > hiec_pkg::HIEC_CIPH_DES56;
  endsequence
  a_done_set: assert property (s_fire |=> sym_queue_done_status_o)
    else $error("done status not set");
  a_hush_quiet: assert property (s_hush |=> !sym_queue_done_status_o)
    else $error("suppressed record set status");
  a_done_clears: assert property (s_clear |=> !sym_queue_done_status_o && !sym_queue_drained_status_o)
    else $error("done clear failed");
  a_done_sticky: assert property (sym_queue_done_status_o && !status_clear_we_i |=> sym_queue_done_status_o)
    else $error("done status dropped");
  a_drain_on: assert property ($rose(sym_queue_empty_i) && sym_queue_irq_enable_i |=> sym_queue_drained_status_o)
    else $error("drained status not set");
  a_fault_set: assert property (dma_fault_i && dma_fault_irq_enable_i |=> dma_fault_status_o)
    else $error("fault status not set");
  a_strong_refused: assert property (s_strong |=> cipher_refuse_o && !cipher_grant_o)
    else $error("strong cipher not refused");
  a_bus_swap: assert property (!normal_bus_flag_o |=> bus_data_o ==
    {$past(bus_data_i[7:0]), $past(bus_data_i[15:8]), $past(bus_data_i[23:16]), $past(bus_data_i[31:24])})
    else $error("bus word not swapped");
endmodule
bind hiec_ctrl hiec_ctrl_properties hiec_ctrl_properties_inst (.*);

// [verif/hiec_ctrl_tb_top.sv]
// self-checking bench of the host control block
`timescale 1ns/100ps
module hiec_ctrl_tb_top;
  logic ref_clk_i = 1'b0, nrst_i = 1'b0, sym_queue_irq_enable_i = '0, asym_queue_irq_enable_i = '0;
  logic dma_fault_irq_enable_i = '0, sym_record_done_i = '0, sym_record_suppress_i = '0, asym_record_done_i = '0;
  logic asym_record_suppress_i = '0, sym_queue_empty_i = '0, asym_queue_empty_i = '0, dma_fault_i = '0;
  logic flags_we_i = '0, little_endian_host_flag_i = '0, normal_bus_flag_i = '0, export_pin_i = 1'b1;
  logic export_pin_oe_i = '0, cipher_req_valid_i = '0, status_clear_we_i, cipher_grant_o, cipher_refuse_o;
  logic export_mode_o, irq_o, little_endian_host_flag_o, normal_bus_flag_o, sym_queue_done_status_o;
  logic asym_queue_done_status_o, sym_queue_drained_status_o, asym_queue_drained_status_o, dma_fault_status_o;
  logic [hiec_pkg::HIEC_ST_W-1:0] status_clear_i;
  logic [31:0] dma_data_i = '0, bus_data_i = '0, dma_data_o, bus_data_o;
  hiec_pkg::hiec_cipher_t cipher_req_i = hiec_pkg::HIEC_CIPH_NONE;
  hiec_pkg::hiec_dma_kind_t dma_kind_i = hiec_pkg::HIEC_DS_PAYLOAD;
  int num_errors = 0, n_tests = 0, cyc = 0;
  hiec_ctrl hiec_ctrl_inst (.*);
  hiec_host_model hiec_host_model_inst (.ref_clk_i, .clear_we_o(status_clear_we_i), .clear_o(status_clear_i));
  always #4 ref_clk_i = ~ref_clk_i;
  task tick;
    @(posedge ref_clk_i);
    #1;
  endtask
  task chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      num_errors++;
      conclude;
    end
  end
  task t_irq;
    {sym_queue_irq_enable_i, sym_record_done_i} = 2'h3;
    tick;
    sym_record_done_i = 1'b0;
    chk("sym done", {irq_o, sym_queue_done_status_o}, 2'h3);
    hiec_host_model_inst.w1c(5'h00);
    chk("zero write", sym_queue_done_status_o, 1'b1);
    hiec_host_model_inst.w1c(5'h01);
    chk("done clear", {irq_o, sym_queue_done_status_o}, 2'h0);
    {sym_record_done_i, sym_record_suppress_i} = 2'h3;
    tick;
    chk("suppress", sym_queue_done_status_o, 1'b0);
    {sym_queue_irq_enable_i, asym_queue_irq_enable_i, sym_record_suppress_i, asym_record_done_i} = 4'h5;
    tick;
    {sym_record_done_i, asym_record_done_i} = 2'h0;
    chk("queue enables", {sym_queue_done_status_o, asym_queue_done_status_o}, 2'h1);
    hiec_host_model_inst.w1c(5'h02);
    {asym_record_done_i, asym_record_suppress_i} = 2'h3;
    tick;
    {asym_record_done_i, asym_record_suppress_i} = 2'h0;
    chk("asym suppress", asym_queue_done_status_o, 1'b0);
    $display("irq test ended");
  endtask
  task t_drain;
    {sym_queue_irq_enable_i, sym_queue_empty_i, asym_queue_empty_i, dma_fault_i} = 4'hf;
    tick;
    {dma_fault_irq_enable_i, sym_record_done_i} = 2'h3;
    chk("drained", {sym_queue_drained_status_o, asym_queue_drained_status_o, dma_fault_status_o}, 3'h6);
    tick;
    {dma_fault_i, sym_record_done_i} = 2'h0;
    chk("fault", dma_fault_status_o, 1'b1);
    hiec_host_model_inst.w1c(5'h19);
    chk("drain clear", {sym_queue_drained_status_o, asym_queue_drained_status_o, irq_o}, 3'h0);
    $display("drain test ended");
  endtask
  task t_export;
    for (int m = 0; m < 2; m++)
    begin
      // first pass leaves the low pin undriven so only the pull-up decides the mode; second pass drives it low
      {export_pin_oe_i, export_pin_i, cipher_req_valid_i} = m ? 3'h5 : 3'h1;
      tick;
      tick;
      chk("export mode", export_mode_o, m == 0);
      for (int c = 0; c < 5; c++)
      begin
        cipher_req_i = hiec_pkg::hiec_cipher_t'(c);
        tick;
        chk("cipher", {cipher_grant_o, cipher_refuse_o}, (m || c < 2) ? 2'h2 : 2'h1);
      end
    end
    cipher_req_valid_i = 1'b0;
    $display("export test ended");
  endtask
  task t_swap;
    {flags_we_i, dma_data_i, bus_data_i} = {1'b1, 64'h1122_3344_5566_7788};
    tick;
    flags_we_i = 1'b0;
    chk("flags", {little_endian_host_flag_o, normal_bus_flag_o}, 2'h0);
    for (int k = 0; k < 6; k++)
    begin
      dma_kind_i = hiec_pkg::hiec_dma_kind_t'(k);
      tick;
      chk("words", {dma_data_o, bus_data_o}, {k ? 32'h4433_2211 : 32'h1122_3344, 32'h8877_6655});
    end
    {flags_we_i, little_endian_host_flag_i, normal_bus_flag_i} = 3'h7;
    tick;
    flags_we_i = 1'b0;
    tick;
    chk("no swap", {dma_data_o, bus_data_o}, 64'h1122_3344_5566_7788);
    $display("swap test ended");
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk_i);
    #1 nrst_i = 1'b1;
    repeat (3) tick;
    chk("reset flags", {little_endian_host_flag_o, normal_bus_flag_o, export_mode_o, irq_o}, 4'he);
    t_irq;
    t_drain;
    t_export;
    t_swap;
    conclude;
  end
endmodule

// [verif/hiec_host_model.sv]
// host model: acknowledges status bits with one-cycle write-one-to-clear writes
`timescale 1ns/100ps
module hiec_host_model (
  input wire logic ref_clk_i,
  output logic clear_we_o = 1'b0,
  output logic [hiec_pkg::HIEC_ST_W-1:0] clear_o = '0
);
  task w1c(input logic [hiec_pkg::HIEC_ST_W-1:0] mask);
    clear_o = mask;
    clear_we_o = 1'b1;
    @(posedge ref_clk_i);
    #1 clear_we_o = 1'b0;
    // released mask shows its inverse so a stale value cannot pass for a write
    clear_o = ~mask;
    @(posedge ref_clk_i);
    #1;
  endtask
endmodule
